/* shared/ahm_pkg.sv */
package ahm_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int MASTERS_MAX = 16;
  localparam int REQ_W = 4;
  localparam logic [1:0] TRANS_IDLE = 2'h0;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_ERROR = 2'h1;
  localparam logic [1:0] RESP_RETRY = 2'h2;
  localparam logic [1:0] RESP_SPLIT = 2'h3;
  localparam logic [2:0] SIZE_BYTE = 3'h0;
  localparam logic [2:0] SIZE_HALF = 3'h1;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
  localparam logic [1:0] OFS_HI_HALF = 2'h2;
  localparam logic [1:0] OFS_B0 = 2'h0;
  localparam logic [1:0] OFS_B1 = 2'h1;
  localparam logic [1:0] OFS_B2 = 2'h2;
  localparam logic [1:0] OFS_B3 = 2'h3;
  localparam logic [1:0] OFS_MASK_HALF = 2'h2;
  localparam logic [3:0] LANE_NONE = 4'h0;
  localparam logic [3:0] LANE_ALL = 4'hF;
  localparam logic [3:0] LANE_LO16 = 4'h3;
  localparam logic [3:0] LANE_HI16 = 4'hC;
  localparam logic [3:0] LANE_B0 = 4'h1;
  localparam logic [3:0] LANE_B1 = 4'h2;
  localparam logic [3:0] LANE_B2 = 4'h4;
  localparam logic [3:0] LANE_B3 = 4'h8;
  localparam logic BIG_ENDIAN = 1'b0;

  typedef enum logic [3:0] {
    AHM_IDLE = 4'h1,
    AHM_REQ  = 4'h2,
    AHM_ADDR = 4'h4,
    AHM_DATA = 4'h8
  } ahm_state_t;

  // active byte lanes for a size/offset pair in the fixed endianness
  function automatic logic [3:0] ahm_lanes(input logic [2:0] size, input logic [1:0] ofs);
    logic [3:0] le;
    le = LANE_NONE;
    case (size)
      SIZE_WORD: le = LANE_ALL;
      SIZE_HALF: le = (ofs & OFS_MASK_HALF) == OFS_HI_HALF ? LANE_HI16 : LANE_LO16;
      SIZE_BYTE: begin
        case (ofs)
          OFS_B0: le = LANE_B0;
          OFS_B1: le = LANE_B1;
          OFS_B2: le = LANE_B2;
          default: le = LANE_B3;
        endcase
      end
      default: le = LANE_ALL;
    endcase
    // big endian mirrors the lane order within the word
    ahm_lanes = BIG_ENDIAN ? {le[0], le[1], le[2], le[3]} : le;
  endfunction : ahm_lanes
endpackage : ahm_pkg

/* shared/ahm_bus_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface ahm_bus_if;
  import ahm_pkg::*;
  logic busreq;
  logic lock;
  logic grant;
  logic [1:0] trans;
  logic [ADDR_W-1:0] addr;
  logic [2:0] size;
  logic write;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic ready;
  logic [1:0] resp;
  logic bus_clock_qualifier;

  modport master (
    output busreq, lock, trans, addr, size, write, wdata,
    input grant, rdata, ready, resp, bus_clock_qualifier
  );
  modport slave (
    input busreq, lock, trans, addr, size, write, wdata,
    output grant, rdata, ready, resp, bus_clock_qualifier
  );
endinterface : ahm_bus_if
`default_nettype wire

/* rtl/ahm_lane_extract.sv */
`timescale 1ns/10ps
`default_nettype none
module ahm_lane_extract
  import ahm_pkg::*;
(
  input wire logic [DATA_W-1:0] bus_data_i,
  input wire logic [2:0] size_i,
  input wire logic [1:0] ofs_i,
  output logic [DATA_W-1:0] value_o
);
  logic [3:0] lanes;
  logic [DATA_W-1:0] shifted;
  always_comb begin
    lanes = ahm_lanes(size_i, ofs_i);
    shifted = bus_data_i;
    if (lanes == LANE_B1) shifted = {8'h00, bus_data_i[31:8]};
    else if (lanes == LANE_B2 || lanes == LANE_HI16) shifted = {16'h0000, bus_data_i[31:16]};
    else if (lanes == LANE_B3) shifted = {24'h000000, bus_data_i[31:24]};
    // only the active lanes reach the result; idle lanes may hold garbage
    value_o = shifted;
    if (size_i == SIZE_BYTE) value_o = {24'h000000, shifted[7:0]};
    else if (size_i == SIZE_HALF) value_o = {16'h0000, shifted[15:0]};
  end
endmodule : ahm_lane_extract
`default_nettype wire

/* rtl/ahm_master.sv */
`timescale 1ns/10ps
`default_nettype none
module ahm_master
  import ahm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  ahm_bus_if.master bus,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_lock_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [2:0] req_size_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  output logic req_ready_o,
  output logic done_o,
  output logic done_ok_o,
  output logic [1:0] done_resp_o,
  output logic [DATA_W-1:0] rdata_o
);
  ahm_state_t state_ff;
  logic busreq_ff, lock_ff, write_ff, req_ready_ff, done_ff, done_ok_ff;
  logic [1:0] trans_ff, resp_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [2:0] size_ff;
  logic [DATA_W-1:0] wdata_ff, rdata_ff, hold_wdata_ff;
  logic qual;
  logic [DATA_W-1:0] lane_value;
  logic granted;
  logic [DATA_W-1:0] rep_wdata;
  logic take_req, addr_start, addr_done, data_done;

  // qualifier gates this bus interface and req_ready_o; the done flags still update on every edge
  assign qual = bus.bus_clock_qualifier;
  assign granted = bus.grant && bus.ready;

  // progress decodes shared by the per-concern flops; each already carries the qualifier
  assign take_req = qual && (state_ff == AHM_IDLE) && req_valid_i;
  assign addr_start = qual && (state_ff == AHM_REQ) && granted;
  assign addr_done = qual && (state_ff == AHM_ADDR) && bus.ready;
  assign data_done = qual && (state_ff == AHM_DATA) && bus.ready;

  always_comb begin
    rep_wdata = req_wdata_i;
    if (req_size_i == SIZE_BYTE) rep_wdata = {4{req_wdata_i[7:0]}};
    else if (req_size_i == SIZE_HALF) rep_wdata = {2{req_wdata_i[15:0]}};
  end

  // endianness is a build-time package constant; nothing here can switch it
  ahm_lane_extract u_extract (
    .bus_data_i(bus.rdata),
    .size_i(size_ff),
    .ofs_i(addr_ff[1:0]),
    .value_o(lane_value)
  );

  // rising edge only, synchronous reset releases cleanly after an edge
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      state_ff <= AHM_IDLE;
    end else if (qual) begin
      case (state_ff)
        AHM_IDLE: begin
          if (req_valid_i) begin
            state_ff <= AHM_REQ;
          end
        end
        AHM_REQ: begin
          if (granted) begin
            state_ff <= AHM_ADDR;
          end
        end
        AHM_ADDR: begin
          if (bus.ready) begin
            state_ff <= AHM_DATA;
          end
        end
        AHM_DATA: begin
          if (bus.ready) begin
            state_ff <= AHM_IDLE;
          end
        end
        default: begin
          state_ff <= AHM_IDLE;
        end
      endcase
    end
  end

  // dedicated request line, held from capture until the address is taken
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      busreq_ff <= 1'b0;
    end else if (take_req) begin
      busreq_ff <= 1'b1;
    end else if (addr_done) begin
      busreq_ff <= 1'b0;
    end
  end

  // lock rises with the request, so it stands at least a cycle before the address
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      lock_ff <= 1'b0;
    end else if (take_req) begin
      lock_ff <= req_lock_i;
    end else if (data_done) begin
      lock_ff <= 1'b0;
    end
  end

  // transfer type is nonsequential for exactly the accepted address phase
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      trans_ff <= TRANS_IDLE;
    end else if (addr_start) begin
      trans_ff <= TRANS_NONSEQ;
    end else if (addr_done) begin
      trans_ff <= TRANS_IDLE;
    end
  end

  // address and control stand from capture to the end of the data phase
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      addr_ff <= ADDR_RST;
      size_ff <= SIZE_WORD;
      write_ff <= 1'b0;
      hold_wdata_ff <= DATA_RST;
    end else if (take_req) begin
      addr_ff <= req_addr_i;
      size_ff <= req_size_i;
      write_ff <= req_write_i;
      hold_wdata_ff <= rep_wdata;
    end
  end

  // write data enters the bus with the data phase and is held through waits
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wdata_ff <= DATA_RST;
    end else if (addr_done) begin
      wdata_ff <= hold_wdata_ff;
    end
  end

  // ready for the user: while idle with nothing asked, and as a pulse at completion
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      req_ready_ff <= 1'b0;
    end else if (qual) begin
      req_ready_ff <= data_done || (state_ff == AHM_IDLE && !req_valid_i);
    end
  end

  // non-okay answers are two cycles; the second has ready high
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      done_ff <= 1'b0;
      done_ok_ff <= 1'b0;
      resp_ff <= RESP_OKAY;
    end else begin
      done_ff <= data_done;
      done_ok_ff <= data_done && (bus.resp == RESP_OKAY);
      if (data_done) begin
        resp_ff <= bus.resp;
      end
    end
  end

  // failed reads keep the last good value; the data bus is not trusted then
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rdata_ff <= DATA_RST;
    end else if (data_done && !write_ff && bus.resp == RESP_OKAY) begin
      rdata_ff <= lane_value;
    end
  end

  assign bus.busreq = busreq_ff;
  assign bus.lock = lock_ff;
  assign bus.trans = trans_ff;
  assign bus.addr = addr_ff;
  assign bus.size = size_ff;
  assign bus.write = write_ff;
  assign bus.wdata = wdata_ff;
  assign req_ready_o = req_ready_ff;
  assign done_o = done_ff;
  assign done_ok_o = done_ok_ff;
  assign done_resp_o = resp_ff;
  assign rdata_o = rdata_ff;
endmodule : ahm_master
`default_nettype wire

/* rtl/ahm_slave_arb.sv */
`timescale 1ns/10ps
`default_nettype none
module ahm_slave_arb
  import ahm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  ahm_bus_if.slave bus,
  input wire logic qual_i,
  input wire logic grant_en_i,
  input wire logic wait_i,
  input wire logic [1:0] resp_i,
  input wire logic [DATA_W-1:0] rdata_i,
  output logic seen_o,
  output logic [ADDR_W-1:0] seen_addr_o,
  output logic [DATA_W-1:0] seen_wdata_o
);
  logic grant_ff, ready_ff, qual_ff, seen_ff, active_ff, second_ff, locked_ff;
  logic [1:0] resp_ff;
  logic [DATA_W-1:0] rdata_ff, wdata_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [3:0] lanes;

  assign lanes = ahm_lanes(bus.size, bus.addr[1:0]);

  // single master seen here; lock keeps grant once a locked run starts
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      grant_ff <= 1'b0;
      locked_ff <= 1'b0;
      qual_ff <= 1'b1;
    end else begin
      qual_ff <= qual_i;
      // a stale lock would hand out grants the enable never allowed
      if (bus.trans != TRANS_IDLE) locked_ff <= bus.lock;
      else if (!bus.lock) locked_ff <= 1'b0;
      grant_ff <= (bus.busreq && grant_en_i) || (locked_ff && bus.lock);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ready_ff <= 1'b1;
      resp_ff <= RESP_OKAY;
      rdata_ff <= DATA_RST;
      active_ff <= 1'b0;
      second_ff <= 1'b0;
      seen_ff <= 1'b0;
      addr_ff <= ADDR_RST;
      wdata_ff <= DATA_RST;
    end else if (qual_ff) begin
      seen_ff <= 1'b0;
      if (second_ff) begin
        ready_ff <= 1'b1;
        second_ff <= 1'b0;
        active_ff <= 1'b0;
      end else if (active_ff && wait_i) begin
        ready_ff <= 1'b0;
        resp_ff <= RESP_OKAY;
      end else if (active_ff && resp_i != RESP_OKAY) begin
        ready_ff <= 1'b0;
        resp_ff <= resp_i;
        second_ff <= 1'b1;
      end else if (active_ff) begin
        ready_ff <= 1'b1;
        resp_ff <= RESP_OKAY;
        active_ff <= 1'b0;
        seen_ff <= 1'b1;
        // only active lanes are valid; the rest read as zero
        for (int i = 0; i < 4; i++) begin
          rdata_ff[i*8 +: 8] <= lanes[i] ? rdata_i[i*8 +: 8] : 8'h00;
        end
        wdata_ff <= bus.wdata;
      // every beat stands alone, so a burst cut by a new owner leaves nothing pending
      end else if (bus.ready && bus.trans != TRANS_IDLE) begin
        active_ff <= 1'b1;
        addr_ff <= bus.addr;
        ready_ff <= 1'b0;
      end else begin
        ready_ff <= 1'b1;
        resp_ff <= RESP_OKAY;
      end
    end
  end

  assign bus.grant = grant_ff;
  assign bus.ready = ready_ff;
  assign bus.resp = resp_ff;
  assign bus.rdata = rdata_ff;
  assign bus.bus_clock_qualifier = qual_ff;
  assign seen_o = seen_ff;
  assign seen_addr_o = addr_ff;
  assign seen_wdata_o = wdata_ff;
endmodule : ahm_slave_arb
`default_nettype wire

/* tb/ahm_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module ahm_asserts
  import ahm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic busreq,
  input wire logic lock,
  input wire logic grant,
  input wire logic [1:0] trans,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic ready,
  input wire logic [1:0] resp,
  input wire logic bus_clock_qualifier
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  logic ns;
  assign ns = trans == TRANS_NONSEQ;
  a_addr_on_grant: assert property ($rose(ns) |-> $past(grant && ready))
    else $error("address without grant");
  a_lock_with_req: assert property ($rose(lock) |-> busreq)
    else $error("lock without request");
  a_lock_ahead: assert property ($rose(ns) && lock |-> $past(lock))
    else $error("lock late");
  a_grant_on_req: assert property ($rose(grant) |-> $past(busreq))
    else $error("grant without request");
  a_qual_freeze: assert property (!bus_clock_qualifier |=> $stable({trans, addr, busreq, lock}))
    else $error("bus moved while frozen");
  a_wait_holds_data: assert property (!ready |=> $stable(wdata))
    else $error("write data moved in wait");
  a_addr_one_cycle: assert property (ns && ready && bus_clock_qualifier |=> trans == TRANS_IDLE)
    else $error("address phase too long");
  a_resp_two_cycle: assert property (resp != RESP_OKAY && !ready |=> ready && $stable(resp))
    else $error("short error response");
  a_resp_first_low: assert property (resp != RESP_OKAY && ready |-> !$past(ready))
    else $error("error response without first cycle");
  c_locked: cover property (ns && lock);
  c_split: cover property (resp == RESP_SPLIT && ready);
  c_slow: cover property (ns && !bus_clock_qualifier);
  c_wait_state: cover property (!ready ##1 !ready);
endmodule : ahm_asserts
`default_nettype wire

/* tb/ahm_master_data_arbitration_test.sv */
`timescale 1ns/10ps
`default_nettype none
module ahm_master_data_arbitration_test
  import ahm_pkg::*;
;
  logic mclk_i = 1'b0, rstn_i = 1'b0, req_valid_i = 1'b0, req_write_i = 1'b0, req_lock_i = 1'b0;
  logic qual_i = 1'b1, grant_en_i = 1'b1, wait_i = 1'b0, divide = 1'b0;
  logic [2:0] req_size_i = '0, sz;
  logic [1:0] resp_i = '0, done_resp_o;
  logic [31:0] req_addr_i = '0, req_wdata_i = '0, rdata_i = '0, rdata_o, seen_addr_o, seen_wdata_o, ex, rd;
  logic req_ready_o, done_o, done_ok_o, seen_o;
  int o, sh, num_errors = 0, cmp_count = 0;

  ahm_bus_if bus_if ();
  ahm_master u_ahm_master (.mclk_i(mclk_i), .rstn_i(rstn_i), .bus(bus_if.master), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_lock_i(req_lock_i), .req_addr_i(req_addr_i), .req_size_i(req_size_i),
    .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .done_o(done_o), .done_ok_o(done_ok_o),
    .done_resp_o(done_resp_o), .rdata_o(rdata_o));
  ahm_slave_arb u_ahm_slave_arb (.mclk_i(mclk_i), .rstn_i(rstn_i), .bus(bus_if.slave), .qual_i(qual_i),
    .grant_en_i(grant_en_i), .wait_i(wait_i), .resp_i(resp_i), .rdata_i(rdata_i), .seen_o(seen_o),
    .seen_addr_o(seen_addr_o), .seen_wdata_o(seen_wdata_o));
  ahm_asserts u_ahm_asserts (.mclk_i(mclk_i), .rstn_i(rstn_i), .busreq(bus_if.busreq), .lock(bus_if.lock),
    .grant(bus_if.grant), .trans(bus_if.trans), .addr(bus_if.addr), .wdata(bus_if.wdata),
    .ready(bus_if.ready), .resp(bus_if.resp), .bus_clock_qualifier(bus_if.bus_clock_qualifier));

  initial forever #10 mclk_i = ~mclk_i;

  // divided bus: the qualifier admits every other edge only
  always @(negedge mclk_i) qual_i <= divide ? ~qual_i : 1'b1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // slow withholds grant for three edges and keeps wait states in the data phase on an undivided bus;
  // with divide set, wait_i drops before the first qualified edge of the data phase
  task automatic xfer(input logic wr, input logic lk, input logic [2:0] s, input logic [31:0] ad,
                      input logic [31:0] wd, input logic [1:0] rs, input logic slow);
    int n;
    logic got_seen;
    got_seen = 1'b0;
    req_write_i = wr;
    req_lock_i = lk;
    req_size_i = s;
    req_addr_i = ad;
    req_wdata_i = wd;
    resp_i = rs;
    rdata_i = rd;
    grant_en_i = !slow;
    wait_i = slow;
    req_valid_i = 1'b1;
    // the previous done pulse may still stand at entry, so always wait an edge first
    for (n = 0; n < 80; n++) begin
      @(negedge mclk_i);
      if (req_ready_o === 1'b0) req_valid_i = 1'b0;
      if (seen_o === 1'b1) got_seen = 1'b1;
      if (n == 2) grant_en_i = 1'b1;
      if (n == 7) wait_i = 1'b0;
      if (done_o === 1'b1) break;
    end
    chk(32'(done_o), 32'h1);
    chk(32'(req_ready_o), 32'h1);
    chk(32'(got_seen), 32'(rs == RESP_OKAY));
  endtask : xfer

  initial begin
    repeat (5000) @(posedge mclk_i);
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (6) @(negedge mclk_i);
    chk(32'(bus_if.trans), 32'(TRANS_IDLE));
    chk(32'(bus_if.busreq), 32'h0);
    rstn_i = 1'b1;
    for (int k = 0; k < 7; k++) begin
      sz = k == 0 ? SIZE_WORD : (k < 3 ? SIZE_HALF : SIZE_BYTE);
      o = k == 0 ? 0 : (k < 3 ? 2 * (k - 1) : k - 3);
      rd = 32'h8765_4321 + 32'(k);
      xfer(1'b0, k[0], sz, 32'h100 + 32'(o), 32'h0, RESP_OKAY, k > 4);
      sh = BIG_ENDIAN ? (sz == SIZE_BYTE ? 3 - o : (sz == SIZE_HALF ? 2 - o : 0)) : o;
      ex = (rd >> (8 * sh)) & (sz == SIZE_BYTE ? 32'hFF : (sz == SIZE_HALF ? 32'hFFFF : 32'hFFFF_FFFF));
      chk(rdata_o, ex);
      chk(32'(done_ok_o), 32'h1);
    end
    // failed reads must leave the last good value in place
    for (int k = 1; k < 4; k++) begin
      rd = 32'hDEAD_BEEF;
      xfer(1'b0, 1'b0, SIZE_WORD, 32'h200, 32'h0, 2'(k), 1'b0);
      chk(32'(done_resp_o), 32'(k));
      chk(32'(done_ok_o), 32'h0);
      chk(rdata_o, ex);
    end
    divide = 1'b1;
    xfer(1'b1, 1'b1, SIZE_BYTE, 32'h303, 32'h0000_00A5, RESP_OKAY, 1'b0);
    chk(seen_wdata_o, 32'hA5A5_A5A5);
    chk(seen_addr_o, 32'h303);
    xfer(1'b1, 1'b0, SIZE_HALF, 32'h302, 32'h0000_1234, RESP_OKAY, 1'b1);
    chk(seen_wdata_o, 32'h1234_1234);
    chk(rdata_o, ex);
    divide = 1'b0;
    complete_run();
  end
endmodule : ahm_master_data_arbitration_test
`default_nettype wire
